// [nbc_host.sv]
// nbc_host: host-side sequencer that drives a large-page flash over its strobed pins.
// assumes the flash pins are wired straight to pins/io_i/ready_busy_n; the bench
// resolves the shared io bus from io_oe_b and the pulled-up busy line.
`timescale 1ns/1ps
// Contract
// - send a full address as five cycles, column then row, in order
// - column low, column high, three row bytes; unused upper bits driven low
// - command bytes latch with select low, command latch high, others idle
// - keep write protect high through any program or erase sequence
// - address bytes latch with select low, address latch high, others idle
// - data bytes latch with both latches low and write protect high
// - read strobe toggles only with select low, write strobe high, latches low
// - page read is 00h, five addresses, 30h; 00h skipped after a read
// - random output is 05h, column, E0h, repeatable
// - 00h then 35h loads a page for copy-back without output
// - program sequences 80h/10h, 85h/10h and cache 80h/15h
// - block erase is 60h then D0h
// - 85h alone moves the program data column
// - cache read start 00h/31h, cache read exit 34h
module nbc_host (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire nbc_pkg::nbc_req_t req,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done,
  output logic timeout,
  output nbc_pkg::nbc_pins_t pins,
  input wire logic [7:0] io_i,
  input wire logic ready_busy_n
);
  import nbc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_C1, S_AD, S_DI, S_C2, S_WB, S_DO, S_DONE} nbc_st_t;

  nbc_st_t st_reg;
  logic [2:0] ph_reg;
  logic [2:0] ab_reg;
  logic [LEN_W-1:0] idx_reg;
  logic [TMR_W-1:0] tmr_reg;
  nbc_req_t req_reg;
  nbc_info_t info_reg;
  nbc_info_t dec;
  logic [7:0] dbyte_reg;
  logic last_read_reg;
  logic done_reg;
  logic timeout_reg;
  nbc_pins_t pins_reg;
  nbc_pins_t pins_next;
  logic [7:0] io_s;
  logic rb_s;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [5:0] en_cur;
  logic last_byte;
  int pos;

  // phase order C1, AD, DI, C2, WB, DO; returns the first enabled one after 'from'
  function automatic nbc_st_t advance(input int from, input logic [5:0] en);
    nbc_st_t r;
    r = S_DONE;
    for (int i = 5; i >= 0; i--) begin
      if (en[i] && i > from) begin
        case (i)
          0: r = S_C1;
          1: r = S_AD;
          2: r = S_DI;
          3: r = S_C2;
          4: r = S_WB;
          default: r = S_DO;
        endcase
      end
    end
    return r;
  endfunction : advance

  // empty data phases are skipped, so a zero length means none
  function automatic logic [5:0] enables(input nbc_info_t i, input logic [LEN_W-1:0] n);
    return {i.dout && n != '0, i.wb, i.use_c2, i.din && n != '0, i.use_a, i.use_c1};
  endfunction : enables

  // address byte for cycle k; unused upper positions are forced low
  function automatic logic [7:0] addr_byte(input logic [2:0] k, input nbc_req_t r);
    case (k)
      AB_COL_LO: return r.col[COL_SPLIT-1:0];
      AB_COL_HI: return {4'h0, r.col[COL_W-1:COL_SPLIT]};
      AB_ROW_0: return r.row[ROW_SPLIT0-1:0];
      AB_ROW_1: return r.row[ROW_SPLIT1-1:ROW_SPLIT0];
      default: return {5'h00, r.row[ROW_W-1:ROW_SPLIT1]};
    endcase
  endfunction : addr_byte

  // pin inputs come from the flash's own timing, so both are synchronised
  nbc_sync #(.W(9)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d({ready_busy_n, io_i}),
    .q({rb_s, io_s})
  );

  // read bytes wait here; a full FIFO holds off the next read strobe
  nbc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(io_s),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign dec = nbc_decode(req.op, last_read_reg);
  assign en_cur = enables(info_reg, req_reg.len);
  assign pos = int'(st_reg) - 1;
  assign last_byte = idx_reg == req_reg.len - 1'b1;
  // a busy flash is only sent reset or status read
  assign req_ready = st_reg == S_IDLE
    && (rb_s || req.op == OP_RESET || req.op == OP_STATUS);
  assign wr_ready = st_reg == S_DI && ph_reg == 3'h0;
  assign fifo_in_valid = st_reg == S_DO && ph_reg == PH_RD_CAP;
  assign pins = pins_reg;
  assign done = done_reg;
  assign timeout = timeout_reg;

  // operation sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= S_IDLE;
      ph_reg <= 3'h0;
      ab_reg <= 3'h0;
      idx_reg <= '0;
      tmr_reg <= '0;
      req_reg <= '0;
      info_reg <= '0;
    end else begin
      case (st_reg)
        S_IDLE: begin
          if (req_valid && req_ready) begin
            req_reg <= req;
            info_reg <= dec;
            ab_reg <= dec.a_first;
            ph_reg <= 3'h0;
            idx_reg <= '0;
            tmr_reg <= '0;
            st_reg <= advance(-1, enables(dec, req.len));
          end
        end
        S_C1, S_C2: begin
          ph_reg <= (ph_reg == PH_WR_LAST) ? 3'h0 : ph_reg + 3'h1;
          if (ph_reg == PH_WR_LAST) st_reg <= advance(pos, en_cur);
        end
        S_AD: begin
          ph_reg <= (ph_reg == PH_WR_LAST) ? 3'h0 : ph_reg + 3'h1;
          if (ph_reg == PH_WR_LAST) begin
            if (ab_reg == info_reg.a_last) st_reg <= advance(pos, en_cur);
            else ab_reg <= ab_reg + 3'h1;
          end
        end
        S_DI: begin
          // an empty write stream simply stretches the strobe's high time
          if (ph_reg == 3'h0) begin
            if (wr_valid) ph_reg <= 3'h1;
          end else if (ph_reg == PH_WR_LAST) begin
            ph_reg <= 3'h0;
            idx_reg <= last_byte ? '0 : idx_reg + 1'b1;
            if (last_byte) st_reg <= advance(pos, en_cur);
          end else begin
            ph_reg <= ph_reg + 3'h1;
          end
        end
        S_WB: begin
          // the busy line is ignored until the flash has had time to pull it
          if (tmr_reg != '1) tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg >= WB_GUARD && rb_s) begin
            tmr_reg <= '0;
            st_reg <= advance(pos, en_cur);
          end
        end
        S_DO: begin
          if (ph_reg == 3'h0) begin
            if (fifo_in_ready) ph_reg <= 3'h1;
          end else if (ph_reg == PH_RD_LAST) begin
            ph_reg <= 3'h0;
            idx_reg <= last_byte ? '0 : idx_reg + 1'b1;
            if (last_byte) st_reg <= advance(pos, en_cur);
          end else begin
            ph_reg <= ph_reg + 3'h1;
          end
        end
        S_DONE: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // program data byte held for its strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) dbyte_reg <= 8'h00;
    else if (wr_valid && wr_ready) dbyte_reg <= wr_data;
  end

  // a page read right after another may drop its leading code
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) last_read_reg <= 1'b0;
    else if (st_reg == S_DONE) last_read_reg <= req_reg.op == OP_READ;
  end

  // completion and page-load overrun pulses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      done_reg <= st_reg == S_DONE;
      timeout_reg <= st_reg == S_WB && info_reg.page_load && tmr_reg == LOAD_LIMIT;
    end
  end

  // pin values for the next cycle; every pin lags the phase by one edge
  always_comb begin
    pins_next = '0;
    pins_next.cs_n = st_reg == S_IDLE;
    pins_next.we_n = 1'b1;
    pins_next.read_strobe_n = 1'b1;
    pins_next.wp_n = st_reg != S_IDLE && info_reg.modify;
    pins_next.io_o = pins_reg.io_o;
    pins_next.io_oe_b = 1'b1;
    case (st_reg)
      S_C1, S_C2: begin
        pins_next.cle = 1'b1;
        pins_next.io_o = (st_reg == S_C1) ? info_reg.c1 : info_reg.c2;
        pins_next.io_oe_b = 1'b0;
        pins_next.we_n = ph_reg != PH_WE_LOW;
      end
      S_AD: begin
        pins_next.ale = 1'b1;
        pins_next.io_o = addr_byte(ab_reg, req_reg);
        pins_next.io_oe_b = 1'b0;
        pins_next.we_n = ph_reg != PH_WE_LOW;
      end
      S_DI: begin
        pins_next.io_o = dbyte_reg;
        pins_next.io_oe_b = 1'b0;
        pins_next.we_n = ph_reg != PH_WE_LOW;
      end
      S_DO: pins_next.read_strobe_n = ph_reg == 3'h0 || ph_reg > PH_RD_CAP;
      default: pins_next.io_oe_b = 1'b1;
    endcase
  end

  // registered pins; deselected means io released
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) pins_reg <= '{cs_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                              read_strobe_n: 1'b1, wp_n: 1'b0, io_o: 8'h00, io_oe_b: 1'b1};
    else pins_reg <= pins_next;
  end

  // helpers for checking: strobe edge, last command, address count
  logic we_q_reg;
  logic we_rise;
  logic [7:0] prev_cmd_reg;
  logic [2:0] ale_cnt_reg;
  assign we_rise = pins_reg.we_n && !we_q_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      we_q_reg <= 1'b1;
      prev_cmd_reg <= 8'h00;
      ale_cnt_reg <= 3'h0;
    end else begin
      we_q_reg <= pins_reg.we_n;
      if (we_rise && pins_reg.cle) begin
        prev_cmd_reg <= pins_reg.io_o;
        ale_cnt_reg <= 3'h0;
      end else if (we_rise && pins_reg.ale && ale_cnt_reg != 3'h7) begin
        ale_cnt_reg <= ale_cnt_reg + 3'h1;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_latch_excl;
    !(pins.cle && pins.ale);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");

  property p_cmd_latch;
    we_rise && pins.cle |-> !pins.ale && !pins.cs_n && pins.read_strobe_n && !pins.io_oe_b;
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("bad command latch");

  property p_addr_latch;
    we_rise && pins.ale |-> !pins.cle && !pins.cs_n && pins.read_strobe_n;
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("bad address latch");

  property p_data_latch;
    we_rise && !pins.cle && !pins.ale |-> pins.wp_n && !pins.cs_n && pins.read_strobe_n;
  endproperty
  a_data_latch: assert property (p_data_latch) else $error("bad data latch");

  property p_read_strobe;
    $fell(pins.read_strobe_n) |-> (pins.we_n && !pins.cle && !pins.ale && !pins.cs_n)
      [*4] ##1 pins.read_strobe_n;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("bad read strobe");

  property p_five_addr;
    we_rise && pins.cle && (pins.io_o == CMD_READ_GO || pins.io_o == CMD_READ_CB)
      |-> ale_cnt_reg == 3'h5;
  endproperty
  a_five_addr: assert property (p_five_addr) else $error("read without five addresses");

  property p_addr_high_low;
    we_rise && pins.ale && info_reg.a_first == AB_COL_LO
      |-> (ale_cnt_reg != 3'h1 || pins.io_o[7:4] == 4'h0)
      && (ale_cnt_reg != 3'h4 || pins.io_o[7:3] == 5'h00);
  endproperty
  a_addr_high_low: assert property (p_addr_high_low) else $error("upper address bits set");

  property p_wp_confirm;
    we_rise && pins.cle && (pins.io_o == CMD_PROG_GO || pins.io_o == CMD_CACHE_GO
      || pins.io_o == CMD_ERASE_GO) |-> pins.wp_n && $past(pins.wp_n, 3);
  endproperty
  a_wp_confirm: assert property (p_wp_confirm) else $error("confirm with protect low");

  property p_erase_pair;
    we_rise && pins.cle && pins.io_o == CMD_ERASE_GO |-> prev_cmd_reg == CMD_ERASE;
  endproperty
  a_erase_pair: assert property (p_erase_pair) else $error("erase confirm unpaired");

  property p_rand_out_pair;
    we_rise && pins.cle && pins.io_o == CMD_RAND_OUT_GO
      |-> prev_cmd_reg == CMD_RAND_OUT && ale_cnt_reg == 3'h2;
  endproperty
  a_rand_out_pair: assert property (p_rand_out_pair) else $error("random out unpaired");

  property p_done_idle;
    done |=> pins.cs_n && !pins.wp_n;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("select or protect held after done");
  c_page_read: cover property (we_rise && pins.cle && pins.io_o == CMD_READ_GO ##[1:200] rd_valid);
  c_program: cover property (we_rise && pins.cle && pins.io_o == CMD_PROG_GO);
  c_fifo_full: cover property (st_reg == S_DO && !fifo_in_ready);
endmodule : nbc_host

// [nbc_pkg.sv]
// nbc_pkg: constants, types and command decode for the flash bus host.
// assumes a 10 MHz system clock; all pin timing is counted in its cycles.
package nbc_pkg;
  localparam int CLK_NS = 100;
  localparam int WB_NS = 100;
  localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_US = 30;
  localparam int LOAD_CYC = (LOAD_US * 1000) / CLK_NS;
  localparam int SYNC_LAT = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int PAGE_BYTES = 2112;
  localparam int COL_W = 12;
  localparam int ROW_W = 19;
  localparam int LEN_W = 12;
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] WB_GUARD = TMR_W'(WB_CYC + SYNC_LAT + 1);
  localparam logic [TMR_W-1:0] LOAD_LIMIT = TMR_W'(LOAD_CYC);
  localparam logic [2:0] PH_WE_LOW = 3'h1;
  localparam logic [2:0] PH_WR_LAST = 3'h2;
  localparam logic [2:0] PH_RD_CAP = 3'(SYNC_LAT + 2);
  localparam logic [2:0] PH_RD_LAST = 3'(SYNC_LAT + 3);
  // address cycle indices and field positions
  localparam logic [2:0] AB_COL_LO = 3'h0;
  localparam logic [2:0] AB_COL_HI = 3'h1;
  localparam logic [2:0] AB_ROW_0 = 3'h2;
  localparam logic [2:0] AB_ROW_1 = 3'h3;
  localparam logic [2:0] AB_ROW_2 = 3'h4;
  localparam int COL_SPLIT = 8;
  localparam int ROW_SPLIT0 = 8;
  localparam int ROW_SPLIT1 = 16;
  // command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_READ_CB = 8'h35;
  localparam logic [7:0] CMD_CREAD_GO = 8'h31;
  localparam logic [7:0] CMD_CREAD_EXIT = 8'h34;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_CB = 8'h85;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_CACHE_GO = 8'h15;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RAND_IN = 8'h85;
  localparam logic [7:0] CMD_RAND_OUT = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_GO = 8'hE0;
  localparam logic [7:0] CMD_LOCK = 8'h2A;
  localparam logic [7:0] CMD_LOCK_TIGHT = 8'h2C;
  localparam logic [7:0] CMD_UNLOCK_S = 8'h23;
  localparam logic [7:0] CMD_UNLOCK_E = 8'h24;
  localparam logic [7:0] CMD_LOCK_STAT = 8'h7A;

  typedef enum logic [4:0] {
    OP_READ, OP_READ_CB, OP_READ_ID, OP_RESET, OP_PROG, OP_PROG_CB, OP_PROG_CACHE,
    OP_ERASE, OP_STATUS, OP_RAND_IN, OP_RAND_OUT, OP_CREAD_START, OP_CREAD_EXIT,
    OP_LOCK, OP_LOCK_TIGHT, OP_UNLOCK_S, OP_UNLOCK_E, OP_LOCK_STAT
  } nbc_op_t;

  typedef struct packed {
    nbc_op_t op;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [LEN_W-1:0] len;
  } nbc_req_t;

  typedef struct packed {
    logic cs_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic [7:0] io_o;
    logic io_oe_b;
  } nbc_pins_t;

  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic use_c1;
    logic use_a;
    logic [2:0] a_first;
    logic [2:0] a_last;
    logic use_c2;
    logic din;
    logic wb;
    logic dout;
    logic modify;
    logic page_load;
  } nbc_info_t;

  // phase layout of each operation; skip_c1 drops the leading read code of OP_READ only
  function automatic nbc_info_t nbc_decode(input nbc_op_t op, input logic skip_c1);
    nbc_info_t i;
    i = '0;
    i.use_c1 = 1'b1;
    i.a_last = AB_ROW_2;
    case (op)
      OP_READ: begin
        i.c1 = CMD_READ; i.c2 = CMD_READ_GO; i.use_c1 = !skip_c1; i.use_a = 1'b1;
        i.use_c2 = 1'b1; i.wb = 1'b1; i.dout = 1'b1; i.page_load = 1'b1;
      end
      OP_READ_CB: begin
        i.c1 = CMD_READ; i.c2 = CMD_READ_CB; i.use_a = 1'b1; i.use_c2 = 1'b1;
        i.wb = 1'b1; i.page_load = 1'b1;
      end
      OP_READ_ID: begin
        i.c1 = CMD_READ_ID; i.use_a = 1'b1; i.a_last = AB_COL_LO; i.dout = 1'b1;
      end
      OP_RESET: begin i.c1 = CMD_RESET; i.wb = 1'b1; end
      OP_PROG, OP_PROG_CB, OP_PROG_CACHE: begin
        i.c1 = (op == OP_PROG_CB) ? CMD_PROG_CB : CMD_PROG;
        i.c2 = (op == OP_PROG_CACHE) ? CMD_CACHE_GO : CMD_PROG_GO;
        i.use_a = 1'b1; i.use_c2 = 1'b1; i.din = 1'b1; i.wb = 1'b1; i.modify = 1'b1;
      end
      OP_ERASE: begin
        i.c1 = CMD_ERASE; i.c2 = CMD_ERASE_GO; i.use_a = 1'b1; i.a_first = AB_ROW_0;
        i.use_c2 = 1'b1; i.wb = 1'b1; i.modify = 1'b1;
      end
      OP_STATUS: begin i.c1 = CMD_STATUS; i.dout = 1'b1; end
      OP_RAND_IN: begin
        i.c1 = CMD_RAND_IN; i.use_a = 1'b1; i.a_last = AB_COL_HI; i.din = 1'b1;
        i.modify = 1'b1;
      end
      OP_RAND_OUT: begin
        i.c1 = CMD_RAND_OUT; i.c2 = CMD_RAND_OUT_GO; i.use_a = 1'b1;
        i.a_last = AB_COL_HI; i.use_c2 = 1'b1; i.dout = 1'b1;
      end
      OP_CREAD_START: begin
        i.c1 = CMD_READ; i.c2 = CMD_CREAD_GO; i.use_c2 = 1'b1; i.wb = 1'b1;
        i.dout = 1'b1; i.page_load = 1'b1;
      end
      OP_CREAD_EXIT: begin i.c1 = CMD_CREAD_EXIT; i.wb = 1'b1; end
      OP_LOCK: i.c1 = CMD_LOCK;
      OP_LOCK_TIGHT: i.c1 = CMD_LOCK_TIGHT;
      OP_UNLOCK_S, OP_UNLOCK_E: begin
        i.c1 = (op == OP_UNLOCK_S) ? CMD_UNLOCK_S : CMD_UNLOCK_E;
        i.use_a = 1'b1; i.a_first = AB_ROW_0;
      end
      OP_LOCK_STAT: begin
        i.c1 = CMD_LOCK_STAT; i.use_a = 1'b1; i.a_first = AB_ROW_0; i.dout = 1'b1;
      end
      default: i.c1 = CMD_STATUS;
    endcase
    return i;
  endfunction : nbc_decode
endpackage : nbc_pkg

// [nbc_sync.sv]
// nbc_sync: two-flop synchroniser for a bundle of pin inputs.
// assumes each bit is a level; multi-bit values are only read when settled.
`timescale 1ns/1ps
module nbc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first flop feeds only the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : nbc_sync

// [nbc_fifo.sv]
// nbc_fifo: small valid/ready FIFO for read data heading to the user.
// assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
module nbc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != (AW + 1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : nbc_fifo

// [nbc_flash_model.sv]
// nbc_flash_model: behavioural flash at the far side of the host pins.
// assumes io_wire is the resolved bus and ready_busy_n is pulled up in the bench.
`timescale 1ns/1ps
module nbc_flash_model #(
  parameter int BUSY_NS = 3000
) (
  input wire nbc_pkg::nbc_pins_t pins,
  input wire logic [7:0] io_wire,
  output logic [7:0] io_dev,
  output logic rb_low = 1'b0
);
  import nbc_pkg::*;
  logic [7:0] a [5];
  logic [7:0] din [8];
  logic [7:0] first_c, last_c;
  logic [7:0] dq = 8'h00;
  logic [11:0] col = 12'h000;
  // powers up ready with column and row at zero, so reads need no setup
  logic [18:0] row = 19'h00000;
  int n_addr = 0, n_c = 0, n_din = 0, bad = 0;
  int busy_ns = BUSY_NS; // the bench stretches this to provoke a load overrun
  // a fresh selection starts a fresh sequence
  always @(negedge pins.cs_n) begin
    n_addr = 0;
    n_c = 0;
    n_din = 0;
  end
  // bytes latch on the rising write strobe, only while selected
  always @(posedge pins.we_n) begin
    if (!pins.cs_n) begin
      if (!pins.read_strobe_n || (pins.cle && pins.ale)) bad++;
      if (pins.cle) begin
        if (rb_low && !(io_wire inside {CMD_RESET, CMD_STATUS})) bad++;
        if (!pins.wp_n && io_wire inside {CMD_PROG, CMD_PROG_CB, CMD_PROG_GO, CMD_CACHE_GO,
            CMD_ERASE, CMD_ERASE_GO}) bad++;
        if (n_c == 0) first_c = io_wire;
        last_c = io_wire;
        n_c++;
        if (io_wire inside {CMD_READ_GO, CMD_RAND_OUT_GO}) col = {a[1][3:0], a[0]};
        if (io_wire == CMD_READ_GO) row = {a[4][2:0], a[3], a[2]};
        if (io_wire inside {CMD_READ_GO, CMD_READ_CB, CMD_CREAD_GO, CMD_PROG_GO, CMD_CACHE_GO,
            CMD_ERASE_GO, CMD_RESET, CMD_CREAD_EXIT}) begin
          rb_low = 1'b1;
          // a deselect during the load never cuts the busy time short
          rb_low <= #(busy_ns) 1'b0;
        end
      end else if (pins.ale) begin
        if (n_addr < 5) a[n_addr] = io_wire;
        n_addr++;
      end else begin
        if (!pins.wp_n) bad++;
        if (n_din < 8) din[n_din] = io_wire;
        n_din++;
      end
    end
  end
  // each falling read strobe presents the next column
  always @(negedge pins.read_strobe_n) begin
    if (!pins.cs_n) begin
      if (!pins.we_n || pins.cle || pins.ale) bad++;
      dq = col[7:0] ^ row[7:0];
      col++;
    end
  end
  // a released bus shows the inverse so a stale sample cannot pass
  assign io_dev = (!pins.cs_n && !pins.read_strobe_n) ? dq : ~dq;
endmodule : nbc_flash_model

// [tb.sv]
// tb: self-checking bench for the flash bus host.
// assumes the flash model returns column xor row on each read strobe.
`timescale 1ns/1ps
module tb;
  import nbc_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic [7:0] wr_data = 8'h00;
  nbc_req_t req = '0;
  logic req_ready, wr_ready, rd_valid, done, timeout, rb_low;
  logic [7:0] rd_data, io_dev, io_wire;
  nbc_pins_t pins;
  logic [11:0] held;
  logic [7:0] rq [$];
  int err_count = 0;
  int n_tests = 0;
  int n_to = 0;
  nbc_op_t ops [16] = '{OP_PROG, OP_PROG_CACHE, OP_PROG_CB, OP_ERASE, OP_READ_CB, OP_CREAD_START,
    OP_CREAD_EXIT, OP_LOCK, OP_LOCK_TIGHT, OP_UNLOCK_S, OP_UNLOCK_E, OP_LOCK_STAT, OP_RAND_IN,
    OP_STATUS, OP_READ_ID, OP_RESET};
  logic [15:0] codes [16] = '{16'h8010, 16'h8015, 16'h8510, 16'h60D0, 16'h0035, 16'h0031,
    16'h3434, 16'h2A2A, 16'h2C2C, 16'h2323, 16'h2424, 16'h7A7A, 16'h8585, 16'h7070, 16'h9090,
    16'hFFFF};
  always #50 clock = ~clock;
  // host byte while it drives, flash byte otherwise
  assign io_wire = pins.io_oe_b ? io_dev : pins.io_o;
  nbc_host i_nbc_host (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .timeout(timeout), .pins(pins), .io_i(io_wire), .ready_busy_n(~rb_low));
  nbc_flash_model i_nbc_flash_model (.pins(pins), .io_wire(io_wire), .io_dev(io_dev),
    .rb_low(rb_low));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // offer one op, feed program bytes, pop read bytes after a stall, wait for done
  task automatic run_op(input nbc_op_t op, input logic [11:0] col, input logic [18:0] row,
      input int len, input int stall);
    int nw;
    int c;
    bit took;
    bit fin;
    nw = 0;
    took = 0;
    fin = 0;
    rq.delete();
    n_to = 0;
    req = '{op: op, col: col, row: row, len: LEN_W'(len)};
    req_valid = 1'b1;
    // a request taken at the coming edge must drop at the next falling edge
    #1 took = req_ready;
    for (c = 0; c < 3000 && !(fin && !rd_valid); c++) begin
      @(negedge clock);
      if (took) req_valid = 1'b0;
      took = req_valid && req_ready;
      wr_valid = (nw < len) && (op inside {OP_PROG, OP_PROG_CB, OP_PROG_CACHE, OP_RAND_IN});
      wr_data = 8'hA0 + 8'(nw);
      rd_ready = (c >= stall);
      if (wr_valid && wr_ready) nw++;
      if (rd_valid && rd_ready) rq.push_back(rd_data);
      if (done) fin = 1;
      if (timeout) n_to++;
      if (c == stall - 1) held = i_nbc_flash_model.col;
    end
    if (c >= 3000) begin
      check("op finished", 1, 0);
      end_of_test();
    end
  endtask : run_op
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    check("idle select", 1, pins.cs_n);
    check("idle protect", 0, pins.wp_n);
    run_op(OP_READ, 12'h7FE, 19'h5A5A5, 2, 0);
    check("lead code", CMD_READ, i_nbc_flash_model.first_c);
    check("addr cycles", 5, i_nbc_flash_model.n_addr);
    check("col pad", 0, i_nbc_flash_model.a[1][7:4]);
    check("row pad", 0, i_nbc_flash_model.a[4][7:3]);
    check("row", 19'h5A5A5, i_nbc_flash_model.row);
    check("bytes", 2, rq.size());
    for (int i = 0; i < 2; i++) check("page", 8'((8'hFE + i) ^ 8'hA5), rq[i]);
    check("no overrun", 0, n_to);
    // a load past its limit flags one overrun and still completes
    i_nbc_flash_model.busy_ns = 31000;
    run_op(OP_READ, 12'h000, 19'h00000, 1, 0);
    i_nbc_flash_model.busy_ns = 3000;
    check("overrun", 1, n_to);
    check("slow byte", 8'h00, rq[0]);
    // full buffer must hold off the fifth strobe
    run_op(OP_READ, 12'h010, 19'h00033, 6, 150);
    check("codes", 1, i_nbc_flash_model.n_c);
    check("held", 12'h014, held);
    for (int i = 0; i < 6; i++) check("stream", 8'((8'h10 + i) ^ 8'h33), rq[i]);
    for (int k = 0; k < 2; k++) begin
      run_op(OP_RAND_OUT, 12'(256 + k * 64), 19'h00000, 2, 0);
      check("lead", CMD_RAND_OUT, i_nbc_flash_model.first_c);
      for (int i = 0; i < 2; i++) check("moved", 8'((k * 64 + i) ^ 8'h33), rq[i]);
    end
    run_op(OP_PROG, 12'h004, 19'h00001, 3, 0);
    for (int i = 0; i < 3; i++) check("din", 8'hA0 + i, i_nbc_flash_model.din[i]);
    for (int k = 0; k < 16; k++) begin
      run_op(ops[k], 12'h000, 19'h00000, 0, 0);
      check("first", codes[k][15:8], i_nbc_flash_model.first_c);
      check("last", codes[k][7:0], i_nbc_flash_model.last_c);
    end
    check("faults", 0, i_nbc_flash_model.bad);
    end_of_test();
  end
endmodule : tb
